// *** src/flash_sec_defs.svh ***
// offsets, field positions, reset values and timing counts of the security/status bank
`ifndef FLASH_SEC_DEFS_SVH
`define FLASH_SEC_DEFS_SVH

`define LOCK_CONFIG_OFS       8'h01
`define CMD_WORD_INDEX_OFS    8'h02
`define PROT_STATUS_OFS       8'h03
`define CONFIG_OFS            8'h04

`define SEC_BYTE_ADDR         24'hFFFE0F
`define KEY_GATE_HI           7
`define KEY_GATE_LO           6
`define LOCK_STATE_HI         1
`define LOCK_STATE_LO         0
`define KEY_GATE_ENABLED      2'h2
`define LOCK_UNSECURED        2'h2
`define LOCK_ALL_SET          8'hFF

`define OVERRIDE_BIT          7
`define WS_DONE_BIT           0
`define WAIT_FIELD_HI         3
`define WAIT_FIELD_LO         2
`define WAIT_RESET            2'h3
`define INDEX_WIDTH           3
`define INDEX_RESET           3'h0

`define SETTLE_NS             16
`define SETTLE_CYCLES         ((`SETTLE_NS * 125 + 999) / 1000)

`endif

// *** src/flash_sec_pkg.sv ***
// types of the security/status bank
package flash_sec_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [1:0] wait_t;
	typedef enum logic [2:0] {
		LOAD_IDLE = 3'b001,
		LOAD_WAIT = 3'b010,
		LOAD_DONE = 3'b100
	} load_state_t;
endpackage

// *** src/flash_security_status_regs.sv ***
// security, command index and protection status registers of the flash block
//
// What this block does
// (R01) during reset sequence, load lock register from nonvolatile security byte
// (R02) double bit fault on that read sets every lock register bit
// (R03) lock register reads its contents; software writes are ignored
// (R04) backdoor key enabled only when key gate bits 7:6 equal 10
// (R05) part unsecured only when lock state bits 1:0 equal 10
// (R06) backdoor unlock forces lock state field to 10
// (R07) software should keep spare bits 5:2 erased
// (R08) index field read/write; other index register bits read zero
// (R09) index value selects how many parameter words are accessed
// (R10) protection status register readable, software writes ignored
// (R11) bit 7 reads 1 while protection set by override command
// (R12) writing a wait-state change clears done bit 0
// (R13) done bit sets once reads run with new wait setting
// (R14) while done bit is 0, reads use previous wait setting
// (R15) software polls done bit for 1 before changing clock setup
// (R16) wait field write while command runs is ignored entirely
// (R17) override status holds 0 after reset until override succeeds
`timescale 1ns/100ps
`include "flash_sec_defs.svh"

module flash_security_status_regs #(
	parameter int INDEX_WIDTH = `INDEX_WIDTH
) (
	input  wire logic                    clk_sys,
	input  wire logic                    rst,
	input  wire logic                    clkEn,
	input  wire logic [7:0]              regAddr,
	input  wire logic [7:0]              regWrData,
	input  wire logic                    regWrite,
	input  wire logic                    regRead,
	output logic      [7:0]              regRdData,
	output logic      [23:0]             nvReadAddr,
	output logic                         nvReadReq,
	input  wire logic                    nvReadValid,
	input  wire logic [7:0]              nvReadData,
	input  wire logic                    nvDoubleFault,
	input  wire logic                    backdoorUnlock,
	input  wire logic                    overrideDone,
	input  wire logic                    overrideClear,
	input  wire logic                    commandComplete,
	output logic                         backdoorKeyEnabled,
	output logic                         partUnsecured,
	output logic      [INDEX_WIDTH-1:0]  commandWordIndex,
	output flash_sec_pkg::wait_t         readWaitCycles,
	output logic                         loadDone
);
	import flash_sec_pkg::*;

	localparam int SETTLE = (`SETTLE_CYCLES < 1) ? 1 : `SETTLE_CYCLES;

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	function automatic logic hitWrite(input logic [7:0] ofs);
		hitWrite = regWrite && (regAddr == ofs);
	endfunction

	function automatic logic keyOpen(input byte_t v);
		keyOpen = (v[`KEY_GATE_HI:`KEY_GATE_LO] == `KEY_GATE_ENABLED);
	endfunction

	function automatic logic lockOpen(input byte_t v);
		lockOpen = (v[`LOCK_STATE_HI:`LOCK_STATE_LO] == `LOCK_UNSECURED);
	endfunction

	// ----------------------------------------------------------------
	// reset-time load of lock register
	// ----------------------------------------------------------------
	load_state_t loadState;
	byte_t       lockConfig;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			loadState  <= LOAD_IDLE;
			nvReadReq  <= 1'b0;
			nvReadAddr <= `SEC_BYTE_ADDR;
			loadDone   <= 1'b0;
		end else if (clkEn) begin
			case (loadState)
				LOAD_IDLE: begin
					nvReadReq <= 1'b1; // R01
					loadState <= LOAD_WAIT;
				end
				LOAD_WAIT: begin
					if (nvReadValid) begin
						nvReadReq <= 1'b0;
						loadDone  <= 1'b1;
						loadState <= LOAD_DONE;
					end
				end
				LOAD_DONE: begin
					loadState <= LOAD_DONE;
				end
				default: begin
					loadState <= LOAD_IDLE;
				end
			endcase
		end
	end

	// lock register; bus writes never reach it
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			lockConfig <= `LOCK_ALL_SET;
		end else if (clkEn) begin
			if (loadState == LOAD_WAIT && nvReadValid) begin
				if (nvDoubleFault) begin
					lockConfig <= `LOCK_ALL_SET; // R02
				end else begin
					lockConfig <= nvReadData; // R01
				end
			end else if (loadState == LOAD_DONE && backdoorUnlock) begin
				lockConfig[`LOCK_STATE_HI:`LOCK_STATE_LO] <= `LOCK_UNSECURED; // R06
			end
		end
	end

	// ----------------------------------------------------------------
	// decoded security state
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			backdoorKeyEnabled <= 1'b0;
			partUnsecured      <= 1'b0;
		end else if (clkEn) begin
			backdoorKeyEnabled <= keyOpen(lockConfig); // R04
			partUnsecured      <= lockOpen(lockConfig); // R05
		end
	end

	// ----------------------------------------------------------------
	// command word index
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			commandWordIndex <= INDEX_WIDTH'(`INDEX_RESET);
		end else if (clkEn && hitWrite(`CMD_WORD_INDEX_OFS)) begin
			commandWordIndex <= regWrData[INDEX_WIDTH-1:0]; // R08 R09
		end
	end

	// ----------------------------------------------------------------
	// protection override status
	// ----------------------------------------------------------------
	logic overrideActive;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			overrideActive <= 1'b0; // R17
		end else if (clkEn) begin
			if (overrideDone) begin
				overrideActive <= 1'b1; // R11
			end else if (overrideClear) begin
				overrideActive <= 1'b0; // R11
			end
		end
	end

	// ----------------------------------------------------------------
	// wait-state request and switch
	// ----------------------------------------------------------------
	wait_t requestedWait;
	logic  waitDone;
	logic  [$clog2(SETTLE+1)-1:0] settleCount;
	wire   waitWrite = regWrite && (regAddr == `CONFIG_OFS) && commandComplete; // R16
	wire   waitChange = waitWrite &&
		(regWrData[`WAIT_FIELD_HI:`WAIT_FIELD_LO] != requestedWait);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			requestedWait <= `WAIT_RESET;
		end else if (clkEn && waitChange) begin
			requestedWait <= regWrData[`WAIT_FIELD_HI:`WAIT_FIELD_LO];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			readWaitCycles <= `WAIT_RESET;
			waitDone       <= 1'b1;
			settleCount    <= '0;
		end else if (clkEn) begin
			if (waitChange) begin
				waitDone    <= 1'b0; // R12
				settleCount <= ($clog2(SETTLE+1))'(SETTLE);
			end else if (!waitDone) begin
				if (settleCount > 1) begin
					settleCount <= settleCount - 1'b1; // R14
				end else begin
					readWaitCycles <= requestedWait; // R13
					waitDone       <= 1'b1; // R13
					settleCount    <= '0;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	byte_t next_rdData;

	always_comb begin
		next_rdData = 8'h00;
		case (regAddr)
			`LOCK_CONFIG_OFS: begin
				next_rdData = lockConfig; // R03
			end
			`CMD_WORD_INDEX_OFS: begin
				next_rdData[INDEX_WIDTH-1:0] = commandWordIndex; // R08
			end
			`PROT_STATUS_OFS: begin
				next_rdData[`OVERRIDE_BIT] = overrideActive; // R10 R11
				next_rdData[`WS_DONE_BIT]  = waitDone; // R12 R13
			end
			`CONFIG_OFS: begin
				next_rdData[`WAIT_FIELD_HI:`WAIT_FIELD_LO] = requestedWait;
			end
			default: begin
				next_rdData = 8'h00;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			regRdData <= 8'h00;
		end else if (clkEn) begin
			regRdData <= regRead ? next_rdData : 8'h00;
		end
	end
endmodule

// *** testbench/flash_sec_chk_sva.sv ***
// port assertions for the security/status bank
`timescale 1ns/100ps
`include "flash_sec_defs.svh"
module flash_sec_chk #(parameter int INDEX_WIDTH = `INDEX_WIDTH) (
	input wire logic                   clk_sys,
	input wire logic                   rst,
	input wire logic [7:0]             regAddr,
	input wire logic [7:0]             regWrData,
	input wire logic                   regWrite,
	input wire logic                   regRead,
	input wire logic [7:0]             regRdData,
	input wire logic [23:0]            nvReadAddr,
	input wire logic                   nvReadReq,
	input wire logic                   nvReadValid,
	input wire logic                   nvDoubleFault,
	input wire logic                   backdoorUnlock,
	input wire logic                   commandComplete,
	input wire logic                   backdoorKeyEnabled,
	input wire logic                   partUnsecured,
	input wire logic [INDEX_WIDTH-1:0] commandWordIndex,
	input wire flash_sec_pkg::wait_t   readWaitCycles,
	input wire logic                   loadDone
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_nv_addr: assert property (nvReadReq |-> nvReadAddr == `SEC_BYTE_ADDR)
		else $error("bad nv address");
	a_lock_decode: assert property (
		regRead && regAddr == `LOCK_CONFIG_OFS && loadDone && $past(loadDone) && !backdoorUnlock
		|=> backdoorKeyEnabled == (regRdData[7:6] == 2'h2) && partUnsecured == (regRdData[1:0] == 2'h2))
		else $error("bad lock decode");
	a_unlock_force: assert property (loadDone && backdoorUnlock |-> ##2 partUnsecured)
		else $error("unlock ignored");
	a_fault_locks: assert property (
		nvReadReq && nvReadValid && nvDoubleFault ##1 !backdoorUnlock [*2]
		|=> !backdoorKeyEnabled && !partUnsecured) else $error("fault left open");
	a_index_read: assert property (
		regRead && regAddr == `CMD_WORD_INDEX_OFS |=> regRdData == 8'(commandWordIndex))
		else $error("bad index read");
	a_wait_switch: assert property (
		regWrite && regAddr == `CONFIG_OFS && commandComplete && regWrData[3:2] != readWaitCycles
		|-> ##3 readWaitCycles == $past(regWrData[3:2], 3)) else $error("no wait switch");
	a_wait_hold: assert property (
		regWrite && regAddr == `CONFIG_OFS && commandComplete && regWrData[3:2] != readWaitCycles
		|=> $stable(readWaitCycles) [*2]) else $error("early wait switch");
	a_wait_blocked: assert property (
		regWrite && regAddr == `CONFIG_OFS && !commandComplete |=> $stable(readWaitCycles) [*3])
		else $error("wait changed while busy");
endmodule
bind flash_security_status_regs flash_sec_chk #(.INDEX_WIDTH(INDEX_WIDTH)) chk (.clk_sys, .rst,
	.regAddr, .regWrData, .regWrite, .regRead, .regRdData, .nvReadAddr, .nvReadReq, .nvReadValid,
	.nvDoubleFault, .backdoorUnlock, .commandComplete, .backdoorKeyEnabled, .partUnsecured,
	.commandWordIndex, .readWaitCycles, .loadDone);

// *** testbench/tb_top.sv ***
// testbench for the security/status bank
`timescale 1ns/100ps
`include "flash_sec_defs.svh"
module tb_top;
	import flash_sec_pkg::*;
	logic       clk_sys, rst, clkEn, regWrite, regRead, nvReadValid, nvDoubleFault;
	logic       backdoorUnlock, overrideDone, overrideClear, commandComplete;
	logic       nvReadReq, backdoorKeyEnabled, partUnsecured, loadDone;
	logic [7:0] regAddr, regWrData, regRdData, nvReadData, d;
	logic [23:0] nvReadAddr;
	logic [2:0] commandWordIndex;
	wait_t      readWaitCycles;
	int         failures = 0, checked = 0, cyc = 0;
	flash_security_status_regs dut (.clk_sys, .rst, .clkEn, .regAddr, .regWrData, .regWrite,
		.regRead, .regRdData, .nvReadAddr, .nvReadReq, .nvReadValid, .nvReadData, .nvDoubleFault,
		.backdoorUnlock, .overrideDone, .overrideClear, .commandComplete, .backdoorKeyEnabled,
		.partUnsecured, .commandWordIndex, .readWaitCycles, .loadDone);
	initial begin
		clk_sys = 0;
		forever #4 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 2000) begin
			failures++;
			test_done;
		end
	end
	task automatic test_done;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(string n, logic [7:0] s, logic [7:0] e);
		checked++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] v);
		regAddr <= a;
		regWrData <= v;
		regWrite <= 1'b1;
		@(posedge clk_sys);
		regWrite <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk_sys);
		regRead <= 1'b0;
		#1 d = regRdData;
		@(posedge clk_sys);
	endtask
	task automatic ld(logic [7:0] v, logic f);
		rst <= 1'b1;
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (3) @(posedge clk_sys);
		nvReadValid <= 1'b1;
		nvReadData <= v;
		nvDoubleFault <= f;
		@(posedge clk_sys);
		nvReadValid <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask
	initial begin
		{rst, clkEn, regWrite, regRead, nvReadValid, nvDoubleFault} = 6'b110000;
		{backdoorUnlock, overrideDone, overrideClear, commandComplete} = 4'b0001;
		{regAddr, regWrData, nvReadData} = '0;
		for (int k = 0; k < 4; k++) begin
			ld({k[1:0], 4'hF, k[1:0]}, 1'b0);
			rd(`LOCK_CONFIG_OFS);
			chk("lock", d, {k[1:0], 4'hF, k[1:0]});
			chk("key", backdoorKeyEnabled, k == 2);
			chk("open", partUnsecured, k == 2);
		end
		wr(`LOCK_CONFIG_OFS, 8'h00);
		rd(`LOCK_CONFIG_OFS);
		chk("lockRo", d, 8'hFF);
		ld(8'hBE, 1'b1);
		rd(`LOCK_CONFIG_OFS);
		chk("fault", d, 8'hFF);
		backdoorUnlock <= 1'b1;
		@(posedge clk_sys);
		backdoorUnlock <= 1'b0;
		rd(`LOCK_CONFIG_OFS);
		chk("unlock", d, 8'hFE);
		wr(`CMD_WORD_INDEX_OFS, 8'hFF);
		rd(`CMD_WORD_INDEX_OFS);
		chk("index", d, 8'h07);
		chk("indexOut", commandWordIndex, 8'h07);
		wr(`PROT_STATUS_OFS, 8'h80);
		rd(`PROT_STATUS_OFS);
		chk("stat", d, 8'h01);
		overrideDone <= 1'b1;
		@(posedge clk_sys);
		overrideDone <= 1'b0;
		rd(`PROT_STATUS_OFS);
		chk("ovrOn", d, 8'h81);
		overrideClear <= 1'b1;
		@(posedge clk_sys);
		overrideClear <= 1'b0;
		wr(`PROT_STATUS_OFS, 8'h00);
		rd(`PROT_STATUS_OFS);
		chk("ovrOff", d, 8'h01);
		commandComplete <= 1'b0;
		wr(`CONFIG_OFS, 8'h00);
		repeat (4) @(posedge clk_sys);
		chk("busyWait", readWaitCycles, 8'h03);
		commandComplete <= 1'b1;
		wr(`CONFIG_OFS, 8'h00);
		@(posedge clk_sys);
		chk("oldWait", readWaitCycles, 8'h03);
		rd(`PROT_STATUS_OFS);
		chk("ackLow", d, 8'h00);
		for (int i = 0; i < 8 && d[0] !== 1'b1; i++) rd(`PROT_STATUS_OFS);
		chk("ackHigh", d, 8'h01);
		chk("newWait", readWaitCycles, 8'h00);
		test_done;
	end
endmodule
